// ==== hdl/sac_conv_ctrl.v ====
// Conversion control, parallel and serial result readout
`timescale 1ns/1ps
`include "sac_map.vh"

// ----------------------------------------
// Operating overview
// ----------------------------------------
// A conversion runs for CONV_CYC clocks once the start pin is seen low while
// idle, and busy marks it. An acquisition of ACQ_CYC clocks follows. If the
// start pin is still held low after that, the next conversion starts by itself.
// The result is coded, stored, and offered in one of three ways:
//   parallel bus, with the two byte lanes optionally exchanged;
//   serial slave, shifted on each falling edge of the host's clock;
//   serial master, on a clock made here with 2*SCLK_HALF_CYC clocks a period.
// In master read-after mode busy is stretched over the sixteen-bit frame.
// In master read-during mode the previous result goes out from the start of
// the next conversion. Keep that frame shorter than half the conversion, so that
// digital activity stays out of the critical second half.
// Every pin is synchronised, so the block reacts about three clocks after a
// pin moves. A host must allow for that latency on every edge it drives.

module sac_conv_ctrl #(
   parameter CONV_CYC = `SAC_CONV_CYC,
   parameter ACQ_CYC = `SAC_ACQ_CYC,
   parameter SCLK_HALF_CYC = `SAC_SCLK_HALF_CYC
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire conversion_start_n,
   input wire power_down_input,
   input wire chip_select_n,
   input wire read_enable_n,
   input wire output_coding_select,
   input wire interface_select,
   input wire byte_lane_exchange,
   input wire clock_source_select,
   input wire read_mode_or_chain_input,
   input wire invert_sclk_sync,
   input wire ext_sclk,
   input wire [15:0] sample_code,
   output reg busy_q,
   output reg low_power_q,
   output reg [15:0] data_out_q,
   output reg [15:0] data_oe_n_q,
   output reg serial_data_output_q,
   output reg serial_data_oe_n_q,
   output reg sclk_out_q,
   output reg sclk_oe_n_q,
   output reg sync_out_q,
   output reg sync_oe_n_q
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Pin order inside both stages, most significant first:
   //   10 conversion start, 9 chip select, 8 read enable, 7 external serial clock,
   //   6 power-down, 5 coding select, 4 interface select, 3 byte exchange,
   //   2 clock source, 1 read mode, 0 clock and sync inversion
   // Level pins are synchronised too: a mode pin that flips near an edge
   // must not split one decision between two values
   reg [10:0] s1_q;
   reg [10:0] s2_q;
   reg sclk_prev_q;
   // Two flops per pin; reset values equal the idle level of each pin, so
   // neither a false start nor a false serial clock edge follows reset
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         s1_q <= 11'h700;
         s2_q <= 11'h700;
         sclk_prev_q <= 1'b0;
      end else begin
         s1_q <= {conversion_start_n, chip_select_n, read_enable_n, ext_sclk,
                  power_down_input, output_coding_select, interface_select,
                  byte_lane_exchange, clock_source_select, read_mode_or_chain_input,
                  invert_sclk_sync};
         s2_q <= s1_q;
         sclk_prev_q <= s2_q[7];
      end
   end

   // Synchronised views of the pins
   // Bit 6, power-down, is carried but never read: it may not abort a conversion
   wire cnv_n = s2_q[10];
   wire off = s2_q[9] | s2_q[8];
   // Only the falling edge shifts, which serves a clock parked high or low
   wire ext_fall = sclk_prev_q & ~s2_q[7];
   wire ob_s = s2_q[5];
   wire ser_s = s2_q[4];
   wire swap_s = s2_q[3];
   wire ext_s = s2_q[2];
   wire rdc_s = s2_q[1];
   wire inv_s = s2_q[0];

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Coding: straight binary passes, two's complement flips sign bit
   function [15:0] sac_code;
      input [15:0] raw;
      input ob;
      begin
         sac_code = ob ? raw : (raw ^ `SAC_SIGN_FLIP);
      end
   endfunction

   // One serial step: the next bit moves up to the MSB, a zero fills the LSB
   function [15:0] sac_shl;
      input [15:0] val;
      begin
         sac_shl = {val[14:0], 1'b0};
      end
   endfunction

   // Coded core result, stored at the end of each conversion
   wire [15:0] coded = sac_code(sample_code, ob_s);

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   reg [1:0] st_q;
   reg [15:0] cnt_q;
   reg [15:0] res_q;
   reg [15:0] prev_q;
   reg cnv_prev_q;
   reg master_q;
   reg rdc_q;
   reg [15:0] sh_q;
   reg [4:0] bits_q;
   reg [15:0] div_q;
   reg mclk_q;
   reg ser_act_q;
   wire start_fall = cnv_prev_q & ~cnv_n;
   wire send_done = (bits_q == 5'h0);

   always @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= `SAC_ST_IDLE;
         cnt_q <= 16'h0000;
         res_q <= `SAC_RES_RST;
         prev_q <= `SAC_RES_RST;
         cnv_prev_q <= 1'b1;
         master_q <= 1'b0;
         rdc_q <= 1'b0;
         busy_q <= 1'b0;
         low_power_q <= 1'b1;
         sh_q <= 16'h0000;
         bits_q <= 5'h00;
         div_q <= 16'h0000;
         mclk_q <= 1'b0;
         ser_act_q <= 1'b0;
      end else begin
         cnv_prev_q <= cnv_n;
         case (st_q)
            `SAC_ST_IDLE: begin
               low_power_q <= 1'b1;
               // Falling start edge, or held low while not busy
               if (start_fall || !cnv_n) begin
                  st_q <= `SAC_ST_CONV;
                  cnt_q <= 16'h0000;
                  busy_q <= 1'b1;
                  low_power_q <= 1'b0;
                  // Mode is frozen for the whole conversion and its frame
                  master_q <= ~ext_s;
                  rdc_q <= rdc_s;
                  // Master read-during: previous result goes out now
                  if (!ext_s && rdc_s) begin
                     sh_q <= prev_q;
                     bits_q <= `SAC_BIT_CNT;
                     ser_act_q <= ser_s;
                     div_q <= 16'h0000;
                     mclk_q <= 1'b0;
                  end
               end
            end
            `SAC_ST_CONV: begin
               // Power-down and start are ignored until done
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == CONV_CYC[15:0] - 16'h0001) begin
                  res_q <= coded;
                  prev_q <= coded;
                  low_power_q <= 1'b1;
                  if (master_q && !rdc_q && ser_s) begin
                     st_q <= `SAC_ST_SEND;
                     sh_q <= coded;
                     bits_q <= `SAC_BIT_CNT;
                     ser_act_q <= 1'b1;
                     div_q <= 16'h0000;
                     mclk_q <= 1'b0;
                  end else begin
                     st_q <= `SAC_ST_ACQ;
                     busy_q <= 1'b0;
                     cnt_q <= 16'h0000;
                  end
               end
            end
            `SAC_ST_SEND: begin
               if (send_done && !ser_act_q) begin
                  st_q <= `SAC_ST_ACQ;
                  busy_q <= 1'b0;                 // Released only after 16 bits
                  cnt_q <= 16'h0000;
               end
            end
            `SAC_ST_ACQ: begin
               // Self-timed acquisition before an automatic restart
               cnt_q <= cnt_q + 16'h0001;
               if (cnt_q == ACQ_CYC[15:0] - 16'h0001) begin
                  st_q <= `SAC_ST_IDLE;
               end
            end
            default: st_q <= `SAC_ST_IDLE;
         endcase

         // Master serial clock: bit changes on falling edge, stable for a full period
         // The frame runs on past the end of busy: with a short conversion the
         // previous result would otherwise be cut off part way through
         if (master_q && ser_act_q) begin
            if (div_q == SCLK_HALF_CYC[15:0] - 16'h0001) begin
               div_q <= 16'h0000;
               mclk_q <= ~mclk_q;
               if (mclk_q) begin
                  bits_q <= bits_q - 5'h01;
                  if (bits_q == 5'h01) begin
                     ser_act_q <= 1'b0;
                  end else begin
                     sh_q <= sac_shl(sh_q);
                  end
               end
            end else begin
               div_q <= div_q + 16'h0001;
            end
         end else if (!master_q) begin
            // Slave operation: the generated clock stays parked low
            mclk_q <= 1'b0;
            ser_act_q <= 1'b0;
         end
         // Slave: load result when deselected, shift only while selected
         // A master frame still in flight keeps its shifter outside idle, even when deselected
         if (!master_q || st_q == `SAC_ST_IDLE) begin
            if (off) begin
               sh_q <= (st_q == `SAC_ST_CONV) ? prev_q : res_q;
               bits_q <= `SAC_BIT_CNT;
            end else if (ext_s && ext_fall && bits_q != 5'h00) begin
               sh_q <= sac_shl(sh_q);
               bits_q <= bits_q - 5'h01;
            end
         end
      end
   end

   // ----------------------------------------
   // Output drivers
   // ----------------------------------------
   // Registered pins; enables low while driving, all released when deselected
   always @(posedge ref_clk) begin
      if (sys_rst) begin
         data_out_q <= 16'h0000;
         data_oe_n_q <= 16'hffff;
         serial_data_output_q <= 1'b0;
         serial_data_oe_n_q <= 1'b1;
         sclk_out_q <= 1'b0;
         sclk_oe_n_q <= 1'b1;
         sync_out_q <= 1'b0;
         sync_oe_n_q <= 1'b1;
      end else begin
         // Parallel result with optional lane swap
         // Lane exchange follows the pin live, so a byte-wide host can toggle it
         if (swap_s) begin
            data_out_q <= {res_q[7:0], res_q[15:8]};
         end else begin
            data_out_q <= res_q;
         end
         data_oe_n_q <= {16{off | ser_s}};
         serial_data_output_q <= sh_q[`SAC_MSB];
         serial_data_oe_n_q <= off | ~ser_s;
         // Clock and data leave from the same edge, so they never skew apart
         sclk_out_q <= mclk_q ^ inv_s;
         sync_out_q <= ser_act_q ^ inv_s;
         // Slave operation leaves clock and sync pins to the host
         sclk_oe_n_q <= off | ~ser_s | ext_s;
         sync_oe_n_q <= off | ~ser_s | ext_s;
      end
   end

endmodule

// ==== hdl/sac_map.vh ====
// Constants for the conversion control and result readout block
`ifndef SAC_MAP_VH
`define SAC_MAP_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SAC_CLK_PERIOD_NS 4
`define SAC_CONV_TIME_NS 1400
`define SAC_ACQ_TIME_NS 600
`define SAC_SCLK_HALF_NS 20
`define SAC_CONV_CYC ((`SAC_CONV_TIME_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_ACQ_CYC ((`SAC_ACQ_TIME_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_SCLK_HALF_CYC (`SAC_SCLK_HALF_NS / `SAC_CLK_PERIOD_NS)
// ----------------------------------------
// Result layout
// ----------------------------------------
`define SAC_RES_W 16
`define SAC_BYTE_W 8
`define SAC_MSB 15
`define SAC_BIT_CNT 5'h10
`define SAC_SIGN_FLIP 16'h8000
`define SAC_RES_RST 16'h0000
// ----------------------------------------
// States
// ----------------------------------------
`define SAC_ST_IDLE 2'h0
`define SAC_ST_CONV 2'h1
`define SAC_ST_SEND 2'h2
`define SAC_ST_ACQ 2'h3
`endif

// ==== test/sac_conv_props.sv ====
// Port checker for the conversion control and readout block
`timescale 1ns/1ps
module sac_conv_props #(
   parameter CONV_CYC = 20
) (
   input wire ref_clk,
   input wire sys_rst,
   input wire chip_select_n,
   input wire read_enable_n,
   input wire interface_select,
   input wire clock_source_select,
   input wire invert_sclk_sync,
   input wire busy_q,
   input wire low_power_q,
   input wire [15:0] data_oe_n_q,
   input wire serial_data_output_q,
   input wire serial_data_oe_n_q,
   input wire sclk_out_q,
   input wire sclk_oe_n_q,
   input wire sync_out_q,
   input wire sync_oe_n_q
);
   reg [9:0] len_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Busy width counter; master send stretches busy, so the bound is loose
   always @(posedge ref_clk) begin
      if (sys_rst || !busy_q) len_q <= 10'h000;
      else len_q <= len_q + 10'h001;
   end
   a_deselect_hiz: assert property (
      (chip_select_n | read_enable_n) [*4] |-> &data_oe_n_q && serial_data_oe_n_q &&
      sclk_oe_n_q && sync_oe_n_q) else $error("outputs driven while deselected");
   a_conv_no_abort: assert property (
      $fell(busy_q) |-> len_q >= CONV_CYC - 1) else $error("conversion cut short");
   a_busy_bounded: assert property (
      busy_q |-> len_q < CONV_CYC + 10'h100) else $error("busy never ends");
   a_idle_low_power: assert property (
      !busy_q && $past(!busy_q) |-> low_power_q) else $error("no low power when idle");
   a_par_no_serial: assert property (
      !interface_select [*4] |-> serial_data_oe_n_q && sclk_oe_n_q) else $error("serial on");
   a_ser_no_par: assert property (
      interface_select [*4] |-> &data_oe_n_q) else $error("parallel bus driven in serial");
   a_slave_no_clk: assert property (
      clock_source_select [*4] |-> sclk_oe_n_q && sync_oe_n_q) else $error("slave drives clk");
   a_bit_on_fall: assert property (
      $changed(serial_data_output_q) && !sclk_oe_n_q && $past(!serial_data_oe_n_q) |->
      sclk_out_q == invert_sclk_sync) else $error("bit moved off falling edge");
   a_sync_framed: assert property (
      !sync_oe_n_q && sclk_out_q != invert_sclk_sync |-> sync_out_q != invert_sclk_sync)
      else $error("clock pulse outside sync frame");
endmodule
bind sac_conv_ctrl sac_conv_props #(.CONV_CYC(CONV_CYC)) u_props (.*);

// ==== test/sac_host_model.sv ====
// Host side model: slave serial reader and master serial sampler
`timescale 1ns/1ps
module sac_host_model (
   input wire sdo,
   input wire sclk_in,
   input wire inv,
   input wire go,
   output reg ext_sclk,
   output reg [15:0] word,
   output reg [15:0] mword
);
   wire mclk = sclk_in ^ inv;
   initial ext_sclk = 1'b0;
   // Sample at the uninverted rise, half a bit away from the change
   always @(posedge mclk) mword <= {mword[14:0], sdo};
   // Slave read: 16 pulses of 40 ns high in an 80 ns period, clock parked low outside frames
   always @(posedge go) begin
      repeat (16) begin
         #40 ext_sclk = 1'b1;
         word = {word[14:0], sdo};
         #40 ext_sclk = 1'b0;
      end
   end
endmodule

// ==== test/tb_sac_conv_ctrl.sv ====
// Self-checking bench for conversion control and readout
`timescale 1ns/1ps
`include "sac_map.vh"
module tb_sac_conv_ctrl;
   localparam CC = 20;
   reg ref_clk = 0, sys_rst = 1, cst_n = 1, pd = 0, cs_n = 1, rd_n = 1, ocs = 1;
   reg isel = 0, swp = 0, css = 1, rdm = 0, inv = 0, go = 0;
   reg [15:0] code = 16'h0000, exp;
   wire busy, lp, sdo, sdo_oe_n, sclk, sclk_oe_n, sync, sync_oe_n, ext_sclk;
   wire [15:0] dq, dq_oe_n, word, mword;
   integer error_cnt = 0, compares = 0, cyc = 0, rises = 0, i, n, k;
   always #2 ref_clk = ~ref_clk;
   always @(posedge busy) rises = rises + 1;
   sac_conv_ctrl #(.CONV_CYC(CC), .ACQ_CYC(10)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .conversion_start_n(cst_n), .power_down_input(pd), .chip_select_n(cs_n),
      .read_enable_n(rd_n), .output_coding_select(ocs), .interface_select(isel),
      .byte_lane_exchange(swp), .clock_source_select(css), .read_mode_or_chain_input(rdm),
      .invert_sclk_sync(inv), .ext_sclk(ext_sclk), .sample_code(code), .busy_q(busy),
      .low_power_q(lp), .data_out_q(dq), .data_oe_n_q(dq_oe_n), .serial_data_output_q(sdo),
      .serial_data_oe_n_q(sdo_oe_n), .sclk_out_q(sclk), .sclk_oe_n_q(sclk_oe_n),
      .sync_out_q(sync), .sync_oe_n_q(sync_oe_n));
   sac_host_model u_host (.sdo(sdo), .sclk_in(sclk), .inv(inv), .go(go),
      .ext_sclk(ext_sclk), .word(word), .mword(mword));
   task finish_test;
      begin
         $display("compares %0d error_cnt %0d", compares, error_cnt);
         if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
      begin
         compares = compares + 1;
         if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // One conversion; start and power-down are pulsed mid-busy to try an abort
   task conv(input [15:0] c);
      begin
         code = c;
         @(negedge ref_clk) cst_n = 0;
         repeat (4) @(negedge ref_clk);
         cst_n = 1;
         for (i = 0; i < 20 && !busy; i = i + 1) @(negedge ref_clk);
         for (n = 0; n < 400 && busy; n = n + 1) begin
            cst_n = (n < 3 || n > 6);
            pd = (n > 2 && n < 8);
            @(negedge ref_clk);
         end
         repeat (4) @(negedge ref_clk);
      end
   endtask
   // Hang guard, well above the 1300 or so cycles the run needs
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         finish_test;
      end
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      sys_rst = 0;
      cs_n = 0;
      rd_n = 0;
      for (k = 0; k < 4; k = k + 1) begin
         ocs = k[0];
         swp = k[1];
         conv(16'h3ca5 + k);
         chk("busyln", 1'b1, n >= CC - 1);
         exp = (16'h3ca5 + k) ^ (k[0] ? 16'h0000 : `SAC_SIGN_FLIP);
         chk("par", k[1] ? {exp[7:0], exp[15:8]} : exp, dq);
         chk("paroe", 16'h0000, dq_oe_n);
      end
      rd_n = 1;
      repeat (4) @(negedge ref_clk);
      chk("hiz", 16'hffff, dq_oe_n);
      rises = 0;
      cst_n = 0;
      repeat (300) @(negedge ref_clk);
      cst_n = 1;
      chk("auto", 1'b1, rises >= 6);
      repeat (60) @(negedge ref_clk);
      isel = 1;
      ocs = 1;
      cs_n = 1;
      rd_n = 0;
      conv(16'hb38d);
      cs_n = 0;
      repeat (4) @(negedge ref_clk);
      go = 1;
      repeat (340) @(negedge ref_clk);
      go = 0;
      chk("slave", 16'hb38d, word);
      css = 0;
      conv(16'h9e01);
      chk("mlen", 1'b1, n >= CC + 159);
      chk("mast", 16'h9e01, mword);
      rdm = 1;
      inv = 1;
      cs_n = 1;
      repeat (4) @(negedge ref_clk);
      cs_n = 0;
      conv(16'h1234);
      repeat (200) @(negedge ref_clk);
      chk("mprev", 16'h9e01, mword);
      finish_test;
   end
endmodule
